// *** design/peripheral_space_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none

module peripheral_space_decoder #(
    parameter int NUM_PERIPH = space_decoder_pkg::NUM_PERIPH
) (
    // clock and reset
    input  wire logic                          core_clk_in,
    input  wire logic                          rst_b_in,
    // processor port
    input  wire space_decoder_pkg::cpu_req_t   cpu_req_in,
    output logic                               cpu_ack_out,
    output logic [31:0]                        cpu_rdata_out,
    output logic [31:0]                        boot_addr_out,
    // peripheral side
    output space_decoder_pkg::per_req_t        per_req_out,
    output logic [NUM_PERIPH-1:0]              per_sel_out,
    input  wire logic [NUM_PERIPH-1:0]         per_ack_in,
    input  wire logic [NUM_PERIPH*32-1:0]      per_rdata_in,
    // external memory side
    output space_decoder_pkg::cpu_req_t        mem_req_out,
    input  wire logic                          mem_ack_in,
    input  wire logic [31:0]                   mem_rdata_in
);
    // ****************************************
    // decode
    // ****************************************
    logic                          hit;
    logic [4:0]                    sel;
    logic                          in_window;
    space_decoder_pkg::route_t     route;
    logic                          busy_q;
    logic                          busy_d;
    space_decoder_pkg::route_t     route_q;
    logic [4:0]                    sel_q;
    logic [31:0]                   mux_rdata;

    block_index_decode u_decode (
        .addr_in (cpu_req_in.addr),
        .hit_out (hit),
        .sel_out (sel)
    );

    assign in_window = cpu_req_in.addr >= space_decoder_pkg::WINDOW_BASE
                    && cpu_req_in.addr <= space_decoder_pkg::WINDOW_TOP;

    always_comb begin
        if (!cpu_req_in.device || !in_window) begin
            route = space_decoder_pkg::ROUTE_MEMORY; // R5 R6
        end else if (hit) begin
            route = space_decoder_pkg::ROUTE_PERIPH; // R4
        end else begin
            route = space_decoder_pkg::ROUTE_RESVD;  // R19
        end
    end

    // ****************************************
    // request tracking
    // one access in flight; processor holds request until ack
    // ****************************************
    assign busy_d = busy_q ? !((route_q == space_decoder_pkg::ROUTE_PERIPH && per_ack_in[sel_q])
                               || (route_q == space_decoder_pkg::ROUTE_MEMORY && mem_ack_in)
                               || route_q == space_decoder_pkg::ROUTE_RESVD)
                           : cpu_req_in.valid && !cpu_ack_out;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            busy_q  <= 1'b0;
            route_q <= space_decoder_pkg::ROUTE_MEMORY;
            sel_q   <= 5'h00;
        end else begin
            busy_q <= busy_d;
            if (!busy_q && cpu_req_in.valid && !cpu_ack_out) begin
                route_q <= route;
                sel_q   <= sel;
            end
        end
    end

    // ****************************************
    // downstream requests
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            per_req_out <= '0;
            per_sel_out <= '0;
            mem_req_out <= '0;
        end else if (!busy_q && cpu_req_in.valid && !cpu_ack_out) begin
            if (route == space_decoder_pkg::ROUTE_PERIPH) begin // R4 R7
                per_req_out.valid  <= 1'b1;
                per_req_out.write  <= cpu_req_in.write;
                per_req_out.offset <= cpu_req_in.addr[11:0];
                per_req_out.wdata  <= cpu_req_in.wdata;
                per_req_out.be     <= cpu_req_in.be;
                per_sel_out        <= NUM_PERIPH'(1) << sel;
            end else if (route == space_decoder_pkg::ROUTE_MEMORY) begin // R5 R6
                mem_req_out <= cpu_req_in;
            end
        end else if (busy_q && busy_d) begin
            // hold until the target acks
        end else begin
            per_req_out <= '0;
            per_sel_out <= '0;
            mem_req_out <= '0;
        end
    end

    // ****************************************
    // answer to processor
    // reserved blocks ack at once with zero so the cpu never hangs
    // ****************************************
    assign mux_rdata = per_rdata_in[sel_q*32 +: 32];

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            cpu_ack_out   <= 1'b0;
            cpu_rdata_out <= 32'h0000_0000;
        end else begin
            cpu_ack_out   <= busy_q && !busy_d;
            cpu_rdata_out <= 32'h0000_0000;
            if (busy_q && !busy_d) begin
                if (route_q == space_decoder_pkg::ROUTE_PERIPH) begin
                    cpu_rdata_out <= mux_rdata;
                end else if (route_q == space_decoder_pkg::ROUTE_MEMORY) begin
                    cpu_rdata_out <= mem_rdata_in;
                end // R19
            end
        end
    end

    // ****************************************
    // boot entry
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            boot_addr_out <= space_decoder_pkg::rom_start_location; // R1
        end else begin
            boot_addr_out <= space_decoder_pkg::rom_start_location;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_dev_window_periph: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (!busy_q && cpu_req_in.valid && !cpu_ack_out && route == space_decoder_pkg::ROUTE_PERIPH)
        |=> per_req_out.valid && !mem_req_out.valid) // R4
        else $error("device access in window not sent to peripheral");
    a_plain_to_mem: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (!busy_q && cpu_req_in.valid && !cpu_ack_out && !cpu_req_in.device)
        |=> mem_req_out.valid && per_sel_out == '0) // R6
        else $error("plain access did not reach memory");
    a_dev_outside_mem: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (!busy_q && cpu_req_in.valid && !cpu_ack_out && cpu_req_in.device && !in_window)
        |=> mem_req_out.valid) // R5
        else $error("device access outside window not sent to memory");
    a_resvd_zero_ack: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (!busy_q && cpu_req_in.valid && !cpu_ack_out && route == space_decoder_pkg::ROUTE_RESVD)
        |=> ##1 cpu_ack_out && cpu_rdata_out == 32'h0000_0000 && per_sel_out == '0) // R19
        else $error("reserved access not completed with zero");
    a_block_select: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (!busy_q && cpu_req_in.valid && !cpu_ack_out && route == space_decoder_pkg::ROUTE_PERIPH)
        |=> per_sel_out == NUM_PERIPH'(1) << $past(cpu_req_in.addr[16:12])
            || $past(cpu_req_in.addr[17])) // R7
        else $error("wrong block selected");
    a_emi_block: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_2) |-> hit && sel == space_decoder_pkg::SEL_EXT_MEM_IF) // R9
        else $error("memory interface block not decoded");
    a_desc_block: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2002_2) |-> hit && sel == space_decoder_pkg::SEL_DESCRAMBLER) // R16
        else $error("descrambler block not decoded");
    a_int_lowpower: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_0) |-> hit && sel == space_decoder_pkg::SEL_INT_LOWPOWER) // R8
        else $error("interrupt and low power block not decoded");
    a_async_serial: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_3) |-> hit && sel == space_decoder_pkg::SEL_ASYNC_SERIAL0) // R9
        else $error("first async serial block not decoded");
    a_card_serial: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_6) |-> hit && sel == space_decoder_pkg::SEL_ASYNC_SERIAL3) // R10
        else $error("card slot 1 serial block not decoded");
    a_card_clock: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_8) |-> hit && sel == space_decoder_pkg::SEL_CARD_CLK1) // R11
        else $error("card slot 1 clock block not decoded");
    a_sync_serial: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_a) |-> hit && sel == space_decoder_pkg::SEL_SYNC_SERIAL1) // R12
        else $error("second sync serial block not decoded");
    a_last_pio: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2001_0) |-> hit && sel == space_decoder_pkg::SEL_PARALLEL_IO4) // R13
        else $error("last parallel io block not decoded");
    a_int_level: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2001_1) |-> hit && sel == space_decoder_pkg::SEL_INT_LEVEL) // R14
        else $error("interrupt level block not decoded");
    a_section_dma: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2002_7) |-> hit && sel == space_decoder_pkg::SEL_SECTION_DMA) // R18
        else $error("section filter block not decoded");
    a_resvd_blocks: assert property (@(posedge core_clk_in)
        (cpu_req_in.addr[31:12] == 20'h2000_1 || cpu_req_in.addr[31:12] == 20'h2002_3
         || cpu_req_in.addr[31:12] == 20'h2001_2 || cpu_req_in.addr[31:12] == 20'h2002_8)
        |-> !hit) // R8 R14 R18
        else $error("reserved block selected a peripheral");
    a_single_select: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        $onehot0(per_sel_out)) // R7
        else $error("more than one peripheral selected");
    a_boot_entry: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        boot_addr_out == 32'h7fff_fffe) // R1
        else $error("boot entry wrong");

    c_periph_access: cover property (@(posedge core_clk_in) per_req_out.valid ##[1:20] cpu_ack_out);
    c_mem_access:    cover property (@(posedge core_clk_in) mem_req_out.valid ##[1:20] cpu_ack_out);
    c_resvd_access:  cover property (@(posedge core_clk_in)
        (!busy_q && cpu_req_in.valid && route == space_decoder_pkg::ROUTE_RESVD));

endmodule

`default_nettype wire

// *** design/space_decoder_pkg.sv ***
// Summary of operation
// R1 - boot from rom starts fetching two bytes below top of address space
// R2 - rom image holds short backward jump in last two bytes, chained further
// R3 - window 0x20000000 to 0x3fffffff is on-chip peripheral space
// R4 - device access inside window goes to peripherals, no external cycle
// R5 - device access outside window goes to memory like normal access
// R6 - ordinary load or store inside window always goes to external memory
// R7 - window split into 4 kbyte blocks, one peripheral per block
// R8 - block 0x20000000 interrupt and low power; 0x20001000 reserved
// R9 - 0x20002000 memory interface ctrl; 0x20003000, 0x20004000 async serial 0 and 1
// R10 - 0x20005000, 0x20006000 async serial 2 and 3 for card slots 0, 1
// R11 - 0x20007000, 0x20008000 card clock generators slot 0 and 1
// R12 - 0x20009000, 0x2000a000 sync serial controllers 0 and 1
// R13 - 0x2000b000 pwm counter; 0x2000c000 onward parallel io ports 0 to 4
// R14 - 0x20011000 interrupt level ctrl; 0x20012000 to 0x2001ffff reserved
// R15 - 0x20020000, 0x20021000 first and second video decoder dma
// R16 - 0x20022000 stream descrambler; 0x20023000 reserved
// R17 - 0x20024000 teletext dma; 0x20025000 ieee parallel port dma
// R18 - 0x20026000 block move dma, 0x20027000 section filter dma; rest reserved
// R19 - reserved device access completes, reads zero, writes ignored, no stall
package space_decoder_pkg;

    // ****************************************
    // address map
    // ****************************************
    localparam logic [31:0] WINDOW_BASE          = 32'h2000_0000;
    localparam logic [31:0] WINDOW_TOP           = 32'h3fff_ffff;
    localparam logic [31:0] rom_start_location   = 32'h7fff_fffe;
    localparam int          BLOCK_SHIFT          = 12;
    localparam int          NUM_PERIPH           = 30;
    localparam int          SEL_W                = 5;

    // ****************************************
    // peripheral select codes (block index inside window)
    // ****************************************
    localparam logic [4:0]  SEL_INT_LOWPOWER     = 5'h00;
    localparam logic [4:0]  SEL_EXT_MEM_IF       = 5'h02;
    localparam logic [4:0]  SEL_ASYNC_SERIAL0    = 5'h03;
    localparam logic [4:0]  SEL_ASYNC_SERIAL3    = 5'h06;
    localparam logic [4:0]  SEL_CARD_CLK1        = 5'h08;
    localparam logic [4:0]  SEL_SYNC_SERIAL1     = 5'h0a;
    localparam logic [4:0]  SEL_PARALLEL_IO4     = 5'h10;
    localparam logic [4:0]  SEL_INT_LEVEL        = 5'h11;

    // window blocks 0x20..0x27 are mapped onto select codes 0x12..0x19
    localparam logic [4:0]  HIGH_GROUP_BASE      = 5'h12;
    localparam logic [4:0]  SEL_DESCRAMBLER      = 5'h14;
    localparam logic [4:0]  SEL_SECTION_DMA      = 5'h19;

    typedef enum logic [1:0] {
        ROUTE_MEMORY = 2'b00,
        ROUTE_PERIPH = 2'b01,
        ROUTE_RESVD  = 2'b11
    } route_t;

    typedef struct packed {
        logic        valid;
        logic        device;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } cpu_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] offset;
        logic [31:0] wdata;
        logic [3:0]  be;
    } per_req_t;

endpackage

// *** design/block_index_decode.sv ***
`timescale 1ns/10ps
`default_nettype none

module block_index_decode (
    // address
    input  wire logic [31:0] addr_in,
    // result
    output logic             hit_out,
    output logic [4:0]       sel_out
);
    logic [19:0] blk;

    // ****************************************
    // window and 4k block lookup
    // ****************************************
    always_comb begin
        blk     = addr_in[31:12];
        hit_out = 1'b0;
        sel_out = 5'h00;
        if (addr_in >= space_decoder_pkg::WINDOW_BASE
            && addr_in <= space_decoder_pkg::WINDOW_TOP) begin // R3 R7
            if (blk[19:5] == 15'h1000) begin
                // blocks 0x00..0x11; 0x01 is reserved R8
                if (blk[4:0] <= space_decoder_pkg::SEL_INT_LEVEL
                    && blk[4:0] != 5'h01) begin // R9 R10 R11 R12 R13 R14
                    hit_out = 1'b1;
                    sel_out = blk[4:0];
                end
            end else if (blk[19:3] == 17'h04004) begin
                // blocks 0x20..0x27; 0x23 is reserved R16
                if (blk[2:0] != 3'h3) begin // R15 R17 R18
                    hit_out = 1'b1;
                    sel_out = 5'(space_decoder_pkg::HIGH_GROUP_BASE + 5'(blk[2:0]));
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** dv/far_side_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module far_side_model #(
    parameter int N = 30
) (
    // clock, reset and answer delay
    input  wire logic                        clk_in,
    input  wire logic                        rst_b_in,
    input  wire logic [3:0]                  dly_in,
    // requests from the decoder
    input  wire space_decoder_pkg::per_req_t per_req_in,
    input  wire logic [N-1:0]                per_sel_in,
    input  wire space_decoder_pkg::cpu_req_t mem_req_in,
    // answers
    output logic [N-1:0]                     per_ack_out,
    output logic [N*32-1:0]                  per_rdata_out,
    output logic                             mem_ack_out,
    output logic [31:0]                      mem_rdata_out
);
    logic [3:0] cnt_q;
    logic       ack_q;

    // one ack pulse after dly_in idle cycles; restarts once the request drops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || !(per_req_in.valid || mem_req_in.valid)) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end else if (ack_q) begin
            ack_q <= 1'b0;
        end else if (cnt_q == dly_in) begin
            ack_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // peripheral data outside the ack cycle is inverted so stale values never match
    always_comb begin
        for (int i = 0; i < N; i++) begin
            per_rdata_out[i*32+:32] = {16'hc0de, 16'(i)};
            if (!(ack_q && per_sel_in[i])) begin
                per_rdata_out[i*32+:32] = ~per_rdata_out[i*32+:32];
            end
        end
    end

    assign per_ack_out   = per_req_in.valid ? (per_sel_in & {N{ack_q}}) : '0;
    assign mem_ack_out   = ack_q & mem_req_in.valid;
    assign mem_rdata_out = ack_q ? ~mem_req_in.addr : mem_req_in.addr;
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic                        core_clk  = 1'b0;
    logic                        rst_b     = 1'b0;
    logic [3:0]                  dly       = 4'h0;
    space_decoder_pkg::cpu_req_t cpu_req   = '0;
    space_decoder_pkg::cpu_req_t mem_req;
    space_decoder_pkg::per_req_t per_req;
    logic                        cpu_ack;
    logic                        mem_ack;
    logic [31:0]                 cpu_rdata;
    logic [31:0]                 boot_addr;
    logic [31:0]                 mem_rdata;
    logic [29:0]                 per_sel;
    logic [29:0]                 per_ack;
    logic [959:0]                per_rdata;
    logic [29:0]                 saw_sel;
    logic                        saw_mem;
    logic [31:0]                 got;
    logic [31:0]                 seen_addr;
    logic [11:0]                 seen_off;
    space_decoder_pkg::per_req_t seen_per;
    space_decoder_pkg::cpu_req_t seen_mem;
    int                          waited;
    int                          n_errors  = 0;
    int                          n_checks  = 0;

    always #4 core_clk = ~core_clk;

    peripheral_space_decoder dut (
        .core_clk_in(core_clk), .rst_b_in(rst_b), .cpu_req_in(cpu_req),
        .cpu_ack_out(cpu_ack), .cpu_rdata_out(cpu_rdata), .boot_addr_out(boot_addr),
        .per_req_out(per_req), .per_sel_out(per_sel), .per_ack_in(per_ack),
        .per_rdata_in(per_rdata), .mem_req_out(mem_req), .mem_ack_in(mem_ack),
        .mem_rdata_in(mem_rdata));

    far_side_model far (
        .clk_in(core_clk), .rst_b_in(rst_b), .dly_in(dly), .per_req_in(per_req),
        .per_sel_in(per_sel), .mem_req_in(mem_req), .per_ack_out(per_ack),
        .per_rdata_out(per_rdata), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
        n_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask

    // request held until the ack edge, dropped on that same edge
    task automatic xfer(input logic dev, input logic wr, input logic [31:0] a);
        saw_sel = '0;
        saw_mem = 1'b0;
        waited  = 0;
        cpu_req <= '{1'b1, dev, wr, a, ~a, 4'hf};
        do begin
            @(posedge core_clk);
            waited++;
            saw_sel = saw_sel | per_sel;
            if (per_req.valid === 1'b1) begin
                seen_off = per_req.offset;
                seen_per = per_req;
            end
            if (mem_req.valid === 1'b1) begin
                saw_mem   = 1'b1;
                seen_mem  = mem_req;
                seen_addr = mem_req.addr;
            end
        end while (cpu_ack !== 1'b1 && waited < 40);
        got = cpu_rdata;
        cpu_req <= '0;
        chk("ack_seen", 32'h1, {31'h0, cpu_ack});
        @(posedge core_clk);
    endtask

    function automatic int code_of(input int blk);
        if (blk <= 'h11 && blk != 1) return blk;
        if (blk >= 'h20 && blk <= 'h27 && blk != 'h23) return blk - 'h20 + 'h12;
        return -1;
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_map();
        int c;
        for (int b = 0; b < 'h29; b++) begin
            c = code_of(b);
            xfer(1'b1, 1'b0, 32'h2000_0ff4 + (b << 12));
            if (c < 0) begin
                chk("resv_sel", 32'h0, {2'b0, saw_sel});
                chk("resv_data", 32'h0, got);
            end else begin
                chk("sel", 32'h1 << c, {2'b0, saw_sel});
                chk("offset", 32'h0ff4, {20'h0, seen_off});
                chk("per_wdata", ~(32'h2000_0ff4 + (b << 12)), seen_per.wdata);
                chk("per_ctl", 32'h0000_000f, {27'h0, seen_per.write, seen_per.be});
                chk("data", {16'hc0de, 16'(c)}, got);
            end
            chk("no_mem", 32'h0, {31'h0, saw_mem});
        end
    endtask

    task automatic t_mem();
        logic [31:0] a [5] = '{32'h1fff_fffc, 32'h4000_0000, 32'h8000_2000,
                               32'h2000_3000, 32'h3fff_fffc};
        for (int i = 0; i < 5; i++) begin
            xfer(i < 3, i[0], a[i]);
            chk("mem_used", 32'h1, {31'h0, saw_mem});
            chk("mem_addr", a[i], seen_addr);
            chk("mem_sel", 32'h0, {2'b0, saw_sel});
            chk("mem_wdata", ~a[i], seen_mem.wdata);
            chk("mem_ctl", {26'h0, i < 3, i[0], 4'hf}, {26'h0, seen_mem.device, seen_mem.write, seen_mem.be});
            if (!i[0]) chk("mem_data", ~a[i], got);
        end
    endtask

    // reserved writes under a slow far side must still finish at once
    task automatic t_resv();
        dly <= 4'h7;
        xfer(1'b1, 1'b1, 32'h2000_1008);
        chk("resv_fast", 32'h1, {31'h0, waited <= 4});
        xfer(1'b1, 1'b1, 32'h3fff_fffc);
        chk("resv_quiet", 32'h0, {1'b0, saw_mem, saw_sel});
        xfer(1'b1, 1'b0, 32'h2001_1000);
        chk("slow_data", {16'hc0de, 16'h0011}, got);
        dly <= 4'h0;
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        chk("boot", 32'h7fff_fffe, boot_addr);
        chk("boot_room", 32'h0000_0002, 32'h8000_0000 - boot_addr);
        t_map();
        t_mem();
        t_resv();
        chk("boot_end", 32'h7fff_fffe, boot_addr);
        results();
    end

    initial begin
        #200_000;
        n_errors++;
        results();
    end
endmodule

`default_nettype wire
